// ==== design/ccdp_pixel_pipe.sv ====
`timescale 1ns/100ps
// Functional notes
// RULE_01: controller holds offset word stable at each conversion tick.
// RULE_02: offset word is subtracted after odd/even correction.
// RULE_03: offset word width is 8, 9 or 10 bits by config.
// RULE_04: offset word is unsigned; zero subtracts nothing.
// RULE_05: pixel results leave as unsigned straight binary.
// RULE_06: chip select plus strobe turns data bus into register port.
// RULE_07: five modes: 3ch cds, 3ch sha, 1ch cds, 1ch sha, bayer.
// RULE_08: three-channel modes step red, green, blue each tick.
// RULE_09: order is odd/even offset, bus subtract, then gain.
// RULE_10: three-channel latency 6 ticks, 9 from bus words.
// RULE_11: first pixel of a line in three-channel modes is red.
// RULE_12: line start low resets sequencing to red and even; one-channel modes reset to the pointer channel, bayer to green or blue.
// RULE_13: three-channel colour sets alternate even then odd.
// RULE_14: sha modes need second sample clock held low.
// RULE_15: software disables clamp before three-channel sha.
// RULE_16: one-channel modes hold the pointer-selected channel.
// RULE_17: one-channel latency 6 ticks, 7 from bus words.
// RULE_18: one-channel pixels alternate even and odd from line start.
// RULE_19: controller prefers green or blue for single channel.
// RULE_20: cfg bits 7:6 colour pointer, also steers register writes.
// RULE_21: odd/even offsets are signed -128..127 per colour.
// RULE_22: width bits borrow gain low bits as offset high bits.
// RULE_23: gain is 1 plus word over full scale times 1, 3 or 7.
// RULE_24: result saturates to zero and all ones.
module ccdp_pixel_pipe
    import ccdp_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             conversionClock,
    input  wire logic             lineStart,
    input  wire logic             videoLevelSampleClock,
    input  wire logic [ADC_W-1:0] adcData,
    output logic      [1:0]       adcSelect,
    input  wire logic [OFS_W-1:0] offsetBus,
    input  wire logic [ADC_W-1:0] gainBus,
    input  wire logic             chipSelectN,
    input  wire logic             writeStrobeN,
    input  wire logic             readStrobeN,
    input  wire logic [2:0]       portAddr,
    input  wire logic [ADC_W-1:0] dataIn,
    output logic      [ADC_W-1:0] dataOut,
    output logic                  dataOe
);
    ccdp_state_t st;
    ccdp_state_t next_st;
    ccdp_mode_t  mode;
    logic        convTick;
    logic        single;
    logic        apbWr;
    logic        portWr;
    logic        portRd;
    logic [7:0]  regRd;
    logic [2:0]  rdIdx;

    function automatic ccdp_mode_t decodeMode(input logic [7:0] c2,
                                              input logic bay);
        if (bay)
            return CCDP_BAYER;
        if (c2[CFG2_SINGLE])
            return c2[CFG2_CDS] ? CCDP_1CH_CDS : CCDP_1CH_SHA;
        return c2[CFG2_CDS] ? CCDP_3CH_CDS : CCDP_3CH_SHA;
    endfunction

    function automatic logic mapped(input logic [2:0] idx);
        return idx <= IDX_STATUS || idx == IDX_BAYER;
    endfunction

    function automatic logic [7:0] readReg(input ccdp_state_t s,
                                           input logic [2:0] idx);
        logic [1:0] p;
        p = s.cfg[CFG_PTR+:2];
        if (p == 2'h3)
            p = COL_R;
        unique case (idx)
            IDX_CFG:    return s.cfg;
            IDX_CFG2:   return s.cfg2;
            IDX_ODD:    return s.oddOfs[p];
            IDX_EVEN:   return s.evenOfs[p];
            IDX_STATUS: return {3'h0, s.shaFault, s.bayerBg, s.oddSet,
                                s.colour};
            IDX_BAYER:  return {7'h00, s.bayer};
            default:    return 8'h00;
        endcase
    endfunction

    // corrected pixel for one sample
    function automatic logic [ADC_W-1:0] correct(
        input logic [ADC_W-1:0] adc,
        input logic [7:0]       oe,
        input logic [7:0]       cfg,
        input logic [OFS_W-1:0] ofsRaw,
        input logic [ADC_W-1:0] gRaw);
        logic signed [15:0] sum;
        logic [9:0]         ofs;
        logic [11:0]        g12;
        logic [2:0]         x;
        logic [ADC_W-1:0]   v;
        logic [27:0]        prod;
        logic [28:0]        res;
        ofs = 10'h000;
        g12 = gRaw;
        // borrowed gain bits become offset msbs
        // RULE_22 pin sharing
        if (cfg[CFG_W10]) begin
            ofs = {gRaw[1:0], ofsRaw};
            g12 = {gRaw[11:2], 2'h0};
        end else if (cfg[CFG_W9]) begin
            ofs = {1'b0, gRaw[0], ofsRaw};
            g12 = {gRaw[11:1], 1'b0};
        end else if (cfg[CFG_W8]) begin
            ofs = {2'h0, ofsRaw};
        end
        // RULE_09 fixed order
        // RULE_02 subtract after odd/even
        // RULE_21 signed odd/even offset
        sum = $signed({4'h0, adc}) + 16'($signed(oe)) -
              $signed({6'h00, ofs});
        // RULE_24 saturate low
        if (sum < 0)
            v = '0;
        else if (sum > $signed({4'h0, PIX_MAX}))
            v = PIX_MAX;
        else
            v = sum[ADC_W-1:0];
        // RULE_23 gain scaling
        x = cfg[CFG_X7] ? 3'h7 : cfg[CFG_X3] ? 3'h3 :
            cfg[CFG_X1] ? 3'h1 : 3'h0;
        prod = 28'(v) * 28'(g12) * 28'(x);
        res = 29'(v) + 29'(prod >> 12);
        // RULE_24 saturate high
        return (res > 29'(PIX_MAX)) ? PIX_MAX : res[ADC_W-1:0];
    endfunction

    assign convTick = conversionClock && !st.convPrev;
    assign mode     = decodeMode(st.cfg2, st.bayer);
    assign single   = mode == CCDP_1CH_CDS || mode == CCDP_1CH_SHA;
    assign apbWr    = psel && penable && pwrite;
    // RULE_06 port strobes
    assign portRd   = !chipSelectN && !readStrobeN;
    assign portWr   = !chipSelectN && !writeStrobeN;
    assign rdIdx    = psel ? paddr[4:2] : portAddr;
    assign regRd    = readReg(st, rdIdx);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped(paddr[4:2]);
    assign prdata   = (psel && !pwrite) ? {24'h000000, regRd} : '0;
    assign adcSelect = st.colour;
    assign dataOut  = st.dataOut;
    // let go of the pins in the first write cycle, no fight with the host
    assign dataOe   = st.dataOe && !portWr;

    always_comb begin
        logic [2:0]       wIdx;
        logic [7:0]       wData;
        logic             wEn;
        logic [1:0]       ptr;
        logic [7:0]       oe;
        logic [ADC_W-1:0] gSel;
        logic [OFS_W-1:0] oSel;
        logic [ADC_W-1:0] pix;
        wIdx  = 3'h0;
        wData = 8'h00;
        wEn   = 1'b0;
        ptr   = 2'h0;
        oe    = 8'h00;
        gSel  = '0;
        oSel  = '0;
        pix   = '0;
        next_st = st;
        next_st.convPrev = conversionClock;
        next_st.wrPrev   = portWr;
        // apb wins over the parallel port in the same cycle
        if (apbWr && mapped(paddr[4:2])) begin
            wEn   = 1'b1;
            wIdx  = paddr[4:2];
            wData = pwdata[7:0];
        end else if (portWr && !st.wrPrev) begin
            wEn   = 1'b1;
            wIdx  = portAddr;
            wData = dataIn[7:0];
        end
        // RULE_20 pointer steers writes
        ptr = st.cfg[CFG_PTR+:2];
        if (ptr == 2'h3)
            ptr = COL_R;
        if (wEn) begin
            unique case (wIdx)
                IDX_CFG:    next_st.cfg = wData;
                IDX_CFG2:   next_st.cfg2 = wData;
                IDX_ODD:    next_st.oddOfs[ptr] = wData;
                IDX_EVEN:   next_st.evenOfs[ptr] = wData;
                IDX_BAYER: begin
                    next_st.bayer = wData[0];
                    if (wData[0])
                        next_st.bayerBg = 1'b0;
                end
                default: ;
            endcase
        end
        // RULE_14 sha needs second clock low
        if ((mode == CCDP_3CH_SHA || mode == CCDP_1CH_SHA) &&
            videoLevelSampleClock)
            next_st.shaFault = 1'b1;
        else if (wEn && wIdx == IDX_STATUS && wData[SR_FAULT])
            next_st.shaFault = 1'b0;
        if (convTick) begin
            // RULE_01 bus words taken on tick
            next_st.gDly = {st.gDly[LEAD3-1:0], gainBus};
            next_st.oDly = {st.oDly[LEAD3-1:0], offsetBus};
            // RULE_10 three-channel bus lead
            // RULE_17 one-channel bus lead
            gSel = (mode == CCDP_3CH_CDS || mode == CCDP_3CH_SHA) ?
                   st.gDly[LEAD3] : st.gDly[LEAD1];
            oSel = (mode == CCDP_3CH_CDS || mode == CCDP_3CH_SHA) ?
                   st.oDly[LEAD3] : st.oDly[LEAD1];
            oe = (st.oddSet && mode != CCDP_BAYER) ?
                 st.oddOfs[st.colour] : st.evenOfs[st.colour];
            // RULE_03 width select
            // RULE_04 unsigned offset
            pix = correct(adcData, oe, st.cfg, oSel, gSel);
            next_st.pipe = {st.pipe[PIPE_N-2:0], pix};
            next_st.lsPrev = lineStart;
            // RULE_07 mode sequencing
            // RULE_12 line start resets
            if (!lineStart) begin
                next_st.oddSet = 1'b0;
                next_st.colour = single ? ptr : COL_R;
                if (mode == CCDP_BAYER)
                    next_st.colour = st.bayerBg ? COL_B : COL_G;
            end else if (mode == CCDP_BAYER) begin
                next_st.colour = (st.colour == COL_G) ? COL_B : COL_G;
            end else if (single) begin
                // RULE_16 channel held
                // RULE_18 per-pixel parity
                next_st.colour = ptr;
                next_st.oddSet = !st.oddSet;
            end else begin
                // RULE_08 rgb stepping
                // RULE_11 red first
                // RULE_13 per-set parity
                unique case (st.colour)
                    COL_R:   next_st.colour = COL_G;
                    COL_G:   next_st.colour = COL_B;
                    default: begin
                        next_st.colour = COL_R;
                        next_st.oddSet = !st.oddSet;
                    end
                endcase
            end
            if (mode == CCDP_BAYER && lineStart && !st.lsPrev)
                next_st.bayerBg = !st.bayerBg;
        end
        // RULE_06 bus turnaround
        // RULE_05 straight binary out
        next_st.dataOe = !portWr;
        if (portRd && !portWr)
            next_st.dataOut = {4'h0, readReg(st, portAddr)};
        else
            next_st.dataOut = st.pipe[PIPE_N-1];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st        <= '0;
            st.cfg    <= CFG_RST;
            st.cfg2   <= CFG2_RST;
            st.dataOe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    logic tri3;
    assign tri3 = mode == CCDP_3CH_CDS || mode == CCDP_3CH_SHA;

    property p_line_reset;
        @(posedge core_clk) disable iff (!rst_n)
        convTick && !lineStart && tri3 |=>
            st.colour == COL_R && !st.oddSet;
    endproperty
    a_line_reset: assert property (p_line_reset) // RULE_12
        else $error("line start did not reset to red even");

    property p_rgb_step;
        @(posedge core_clk) disable iff (!rst_n)
        convTick && lineStart && tri3 && st.colour == COL_R |=>
            st.colour == COL_G;
    endproperty
    a_rgb_step: assert property (p_rgb_step) // RULE_08
        else $error("red not followed by green");

    property p_set_parity;
        @(posedge core_clk) disable iff (!rst_n)
        convTick && lineStart && tri3 && st.colour == COL_B |=>
            st.oddSet != $past(st.oddSet) && st.colour == COL_R;
    endproperty
    a_set_parity: assert property (p_set_parity) // RULE_13
        else $error("colour set parity did not toggle");

    property p_single_hold;
        @(posedge core_clk) disable iff (!rst_n)
        convTick && single && st.cfg[7:6] != 2'h3 |=>
            st.colour == $past(st.cfg[7:6]);
    endproperty
    a_single_hold: assert property (p_single_hold) // RULE_16
        else $error("single channel multiplexer moved");

    property p_pixel_parity;
        @(posedge core_clk) disable iff (!rst_n)
        convTick && lineStart && single |=>
            st.oddSet != $past(st.oddSet);
    endproperty
    a_pixel_parity: assert property (p_pixel_parity) // RULE_18
        else $error("single channel parity did not toggle");

    property p_write_release;
        @(posedge core_clk) disable iff (!rst_n)
        !chipSelectN && !writeStrobeN |=> !dataOe;
    endproperty
    a_write_release: assert property (p_write_release) // RULE_06
        else $error("bus driven during register write");

    property p_read_drive;
        @(posedge core_clk) disable iff (!rst_n)
        !chipSelectN && !readStrobeN && writeStrobeN |=>
            dataOe && dataOut[11:8] == 4'h0;
    endproperty
    a_read_drive: assert property (p_read_drive) // RULE_06
        else $error("register read not driven as byte");

    property p_out_on_tick;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(st.pipe[PIPE_N-1]) |-> $past(convTick);
    endproperty
    a_out_on_tick: assert property (p_out_on_tick) // RULE_10
        else $error("pipeline moved without a conversion tick");

    c_full_set: cover property (@(posedge core_clk) disable iff (!rst_n)
        convTick && tri3 && st.colour == COL_B && st.oddSet);
    c_port_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        portRd ##1 dataOe);
    c_saturate: cover property (@(posedge core_clk) disable iff (!rst_n)
        st.pipe[PIPE_N-1] == PIX_MAX);
    c_bayer: cover property (@(posedge core_clk) disable iff (!rst_n)
        mode == CCDP_BAYER && st.bayerBg);
endmodule

// ==== include/ccdp_pkg.sv ====
package ccdp_pkg;
    localparam int ADC_W = 12;
    localparam int OFS_W = 8;
    // register word index, byte address is index * 4
    localparam logic [2:0] IDX_CFG    = 3'h0;
    localparam logic [2:0] IDX_CFG2   = 3'h1;
    localparam logic [2:0] IDX_ODD    = 3'h2;
    localparam logic [2:0] IDX_EVEN   = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;
    localparam logic [2:0] IDX_BAYER  = 3'h7;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] CFG2_RST   = 8'h00;
    // cfg fields
    localparam int CFG_X1  = 0;
    localparam int CFG_X3  = 1;
    localparam int CFG_X7  = 2;
    localparam int CFG_W10 = 3;
    localparam int CFG_W9  = 4;
    localparam int CFG_W8  = 5;
    localparam int CFG_PTR = 6;
    // cfg2 fields, then the status fault bit
    localparam int CFG2_CDS    = 0;
    localparam int CFG2_SINGLE = 1;
    localparam int SR_FAULT    = 4;
    // bus word lead in ticks, minus one
    localparam int LEAD3 = 2;
    localparam int LEAD1 = 0;
    localparam int PIPE_N = 6;
    localparam logic [1:0] COL_R = 2'h0;
    localparam logic [1:0] COL_G = 2'h1;
    localparam logic [1:0] COL_B = 2'h2;
    localparam logic [ADC_W-1:0] PIX_MAX = 12'hFFF;

    typedef enum logic [2:0] {
        CCDP_3CH_CDS, CCDP_3CH_SHA, CCDP_1CH_CDS, CCDP_1CH_SHA, CCDP_BAYER
    } ccdp_mode_t;

    typedef struct packed {
        logic [7:0]                   cfg;
        logic [7:0]                   cfg2;
        logic                         bayer;
        logic                         bayerBg;
        logic [2:0][7:0]              oddOfs;
        logic [2:0][7:0]              evenOfs;
        logic [1:0]                   colour;
        logic                         oddSet;
        logic                         lsPrev;
        logic                         convPrev;
        logic                         wrPrev;
        logic                         shaFault;
        logic [LEAD3:0][ADC_W-1:0]    gDly;
        logic [LEAD3:0][OFS_W-1:0]    oDly;
        logic [PIPE_N-1:0][ADC_W-1:0] pipe;
        logic [ADC_W-1:0]             dataOut;
        logic                         dataOe;
    } ccdp_state_t;
endpackage

// ==== verif/ccd_pixel_digital_pipeline_bench.sv ====
`timescale 1ns/100ps
module ccd_pixel_digital_pipeline_bench
    import ccdp_pkg::*;
;
    logic             core_clk, rst_n, psel, penable, pwrite, pready;
    logic             pslverr, conversionClock, lineStart, dataOe;
    logic             videoLevelSampleClock, chipSelectN, writeStrobeN;
    logic             readStrobeN, lineEnable, cdsMode, breakSha;
    logic             ccPrev, lsPrev;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, r;
    logic [ADC_W-1:0] adcData, gainBus, dataIn, dataOut, hostBus;
    logic [OFS_W-1:0] offsetBus;
    logic [1:0]       adcSelect;
    logic [2:0]       portAddr;
    logic [ADC_W-1:0] adcH [0:1023];
    logic [ADC_W-1:0] gH [0:1023];
    logic [OFS_W-1:0] oH [0:1023];
    logic [7:0]       oddT [3];
    logic [7:0]       evenT [3];
    int               n_fail, n_checks, nTick, lineBase;

    // bus resolved from both drivers
    assign dataIn = dataOe ? dataOut : hostBus;

    ccdp_pixel_pipe uut (.core_clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .conversionClock,
        .lineStart, .videoLevelSampleClock, .adcData, .adcSelect,
        .offsetBus, .gainBus, .chipSelectN, .writeStrobeN, .readStrobeN,
        .portAddr, .dataIn, .dataOut, .dataOe);

    ccdp_ctrl_model partner (.core_clk, .lineEnable, .cdsMode, .breakSha,
        .conversionClock, .lineStart, .videoLevelSampleClock, .adcData,
        .offsetBus, .gainBus);

    // record what the device sees at each conversion tick
    always @(posedge core_clk) begin
        ccPrev <= conversionClock;
        if (conversionClock && !ccPrev) begin
            adcH[nTick] <= adcData;
            oH[nTick] <= offsetBus;
            gH[nTick] <= gainBus;
            if (lineStart && !lsPrev) lineBase <= nTick;
            lsPrev <= lineStart;
            nTick <= nTick + 1;
        end
    end

    task test_done;
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task bad(input string m);
        n_fail++;
        $display("BAD %0t %s", $time, m);
    endtask

    function automatic bit differs(input logic [31:0] a, b);
        n_checks++;
        return a !== b;
    endfunction

    function automatic logic [11:0] pix(input logic [11:0] a, g,
                                        input logic [7:0] ob, oe, cf);
        int         o, v;
        logic [2:0] x;
        logic [11:0] gw;
        o = cf[3] ? int'({g[1:0], ob}) : cf[4] ? int'({g[0], ob})
            : cf[5] ? int'(ob) : 0;
        gw = cf[3] ? {g[11:2], 2'h0} : cf[4] ? {g[11:1], 1'h0} : g;
        x = cf[2] ? 3'h7 : cf[1] ? 3'h3 : cf[0] ? 3'h1 : 3'h0;
        v = int'(a) + int'($signed(oe)) - o;
        v = v < 0 ? 0 : v > int'(PIX_MAX) ? int'(PIX_MAX) : v;
        v = v + v * int'(gw) * int'(x) / 32'h1000;
        return v > int'(PIX_MAX) ? PIX_MAX : v[11:0];
    endfunction

    task automatic apb(input logic w, input logic [2:0] idx,
                       input logic [7:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {3'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad("apb hang");
            test_done();
        end
        r = prdata;
        if (differs(pslverr, idx == 3'h5 || idx == 3'h6)) bad("slverr");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        if (differs(r, {24'h0, e})) bad("register read");
    endtask

    task automatic till(input int tgt);
        for (int i = 0; i < 200 && nTick < tgt; i++) @(posedge core_clk);
        if (nTick < tgt) begin
            bad("tick wait");
            test_done();
        end
    endtask

    task automatic port(input logic w, input logic [2:0] idx,
                        input logic [7:0] d);
        @(posedge core_clk);
        chipSelectN <= 1'b0;
        writeStrobeN <= !w;
        readStrobeN <= w;
        portAddr <= idx;
        hostBus <= {4'h0, d};
        repeat (2) @(posedge core_clk);
        if (differs(dataOe, !w)) bad("port direction");
        if (!w && differs(dataOut, {4'h0, d})) bad("port data");
        chipSelectN <= 1'b1;
        writeStrobeN <= 1'b1;
        readStrobeN <= 1'b1;
    endtask

    task automatic t_regs;
        rchk(IDX_CFG, CFG_RST);
        rchk(IDX_CFG2, CFG2_RST);
        apb(1'b1, 3'h6, 8'hAA);
        rchk(3'h5, 8'h00);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, IDX_CFG, 8'(c << 6));
            apb(1'b1, IDX_ODD, oddT[c]);
            apb(1'b1, IDX_EVEN, evenT[c]);
        end
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, IDX_CFG, 8'(c << 6));
            rchk(IDX_ODD, oddT[c]);
            rchk(IDX_EVEN, evenT[c]);
        end
        apb(1'b1, IDX_BAYER, 8'h01);
        rchk(IDX_BAYER, 8'h01);
        apb(1'b1, IDX_BAYER, 8'h00);
    endtask

    task automatic t_port;
        port(1'b1, IDX_CFG, 8'h5A);
        rchk(IDX_CFG, 8'h5A);
        apb(1'b1, IDX_CFG2, 8'h02);
        port(1'b0, IDX_CFG2, 8'h02);
    endtask

    task automatic t_mode(input logic [7:0] c2, cf, input logic one, bay);
        int b, lead, col, par;
        logic [11:0] e;
        // mode words go in while the line is held inactive
        lineEnable <= 1'b0;
        apb(1'b1, IDX_CFG2, c2);
        apb(1'b1, IDX_CFG, cf);
        apb(1'b1, IDX_BAYER, {7'h00, bay});
        cdsMode <= c2[0];
        till(nTick + 3);
        lineEnable <= 1'b1;
        till(nTick + 4);
        b = lineBase;
        lead = (one || bay) ? 1 : 3;
        for (int t = 3; t < 9; t++) begin
            till(b + t + 6);
            @(posedge core_clk);
            col = bay ? 1 + t % 2 : one ? 1 : t % 3;
            par = bay ? 0 : one ? t % 2 : (t / 3) % 2;
            e = pix(adcH[b+t], gH[b+t-lead], oH[b+t-lead],
                    par ? oddT[col] : evenT[col], cf);
            if (differs(dataOut, e)) bad("pixel value");
            if (differs(adcSelect, col)) bad("mux");
        end
    endtask

    task automatic t_fault;
        apb(1'b1, IDX_CFG2, 8'h80);
        cdsMode <= 1'b0;
        till(nTick + 1);
        apb(1'b1, IDX_STATUS, 8'h10);
        apb(1'b0, IDX_STATUS, 8'h00);
        if (differs(r[SR_FAULT], 1'b0)) bad("fault no cause");
        breakSha <= 1'b1;
        till(nTick + 2);
        breakSha <= 1'b0;
        apb(1'b0, IDX_STATUS, 8'h00);
        if (differs(r[SR_FAULT], 1'b1)) bad("fault not set");
        apb(1'b1, IDX_STATUS, 8'h10);
        apb(1'b0, IDX_STATUS, 8'h00);
        if (differs(r[SR_FAULT], 1'b0)) bad("fault stuck");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        #400000;
        bad("run timeout");
        test_done();
    end

    initial begin
        {rst_n, psel, penable, pwrite, ccPrev, lsPrev} = 6'h00;
        {lineEnable, cdsMode, breakSha} = 3'h0;
        {chipSelectN, writeStrobeN, readStrobeN} = 3'h7;
        paddr = 8'h00;
        pwdata = 32'h0;
        portAddr = 3'h0;
        hostBus = 12'h000;
        {n_fail, n_checks, nTick, lineBase} = {4{32'h0}};
        oddT = '{8'h05, 8'hF0, 8'h7F};
        evenT = '{8'h80, 8'h11, 8'hFE};
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_port();
        t_mode(8'h01, 8'h22, 1'b0, 1'b0);
        // sample-and-hold runs with the input clamp off
        t_mode(8'h80, 8'h14, 1'b0, 1'b0);
        // green channel keeps the full single-channel rate
        t_mode(8'h03, 8'h49, 1'b1, 1'b0);
        t_mode(8'h01, 8'h2A, 1'b0, 1'b1);
        t_mode(8'h82, 8'h40, 1'b1, 1'b0);
        t_fault();
        test_done();
    end
endmodule

// ==== verif/ccdp_ctrl_model.sv ====
`timescale 1ns/100ps
// scanner controller: conversion clock, line start and per-pixel words
module ccdp_ctrl_model
    import ccdp_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             lineEnable,
    input  wire logic             cdsMode,
    input  wire logic             breakSha,
    output logic                  conversionClock,
    output logic                  lineStart,
    output logic                  videoLevelSampleClock,
    output logic      [ADC_W-1:0] adcData,
    output logic      [OFS_W-1:0] offsetBus,
    output logic      [ADC_W-1:0] gainBus
);
    logic [1:0]  ph;
    logic [11:0] n;

    initial begin
        ph = 2'h0;
        n = 12'h000;
        conversionClock = 1'b0;
        lineStart = 1'b0;
        videoLevelSampleClock = 1'b0;
        adcData = 12'h000;
        offsetBus = 8'h00;
        gainBus = 12'h000;
    end

    always @(posedge core_clk) begin
        ph <= ph + 2'h1;
        conversionClock <= ph[1];
        if (ph == 2'h0) begin
            n <= n + 12'h001;
            adcData <= n * 12'h1A7 + 12'h0C0;
            offsetBus <= n[7:0] * 8'h25;
            gainBus <= n * 12'h3B1;
            lineStart <= lineEnable;
        end
        // second clock toggles in cds mode; in sha mode grounded, broken only on command
        videoLevelSampleClock <= cdsMode ? ~ph[1] : breakSha;
    end
endmodule
